// File: rtl/asr_dev.sv
/*
  Converter end of the three-wire readout link: clock-source choice, status flag,
  31-bit result output, abort and restart, serial clock pull-up.
  Assumes the conversion core pulses conv_done_i with its result while converting.
*/
`timescale 1ns/1ps
`include "asr_consts.svh"

// Behaviour
// (RULE1) Clock source chosen at each select fall
// (RULE2) Data out released while select high
// (RULE3) Status flag on data out while selected
// (RULE4) Sleep entered when conversion completes
// (RULE5) Result held until clock rise while selected
// (RULE6) Data changes on clock falling edges
// (RULE7) External mode: 32nd fall starts conversion
// (RULE8) External mode: select rise aborts, restarts conversion
// (RULE9) Clock source latched at power-on end
// (RULE10) Two-wire: result loaded when flag falls
// (RULE11) Two-wire: data high on 32nd fall
// (RULE12) Pull-up on clock pin at select fall
// (RULE13) Internal mode: select low drives clock low
// (RULE14) Internal mode: output after status-test delay
// (RULE15) Early select rise keeps device asleep
// (RULE16) Internal mode: 32 clocks, then hold high
// (RULE17) Internal mode: select rise aborts output
// (RULE18) Pull-up off while clock pin low
// (RULE19) Select rise with clock low: stays low
// (RULE20) Status pulse: pull-up back after select rise
// (RULE21) Result shifted most significant bit first
// (RULE22) Internal clock is conversion clock over eight
// (RULE23) Select and clock inputs synchronised first
module asr_dev
  import asr_pkg::*;
#(
  parameter int unsigned POR_CYCLES = `ASR_POR_CYCLES
) (
  input wire logic clk_i,              // conversion clock
  input wire logic sys_rst_i,          // sync reset, active high
  asr_link_if.dev link,                // three-wire link
  input wire logic ext_osc_sel_i,      // conversion clock from external oscillator
  input wire logic conv_done_i,        // core finished, pulse
  input wire logic [30:0] conv_data_i, // core result
  output logic conv_start_o,           // start core, pulse
  output logic sleep_o,                // in sleep state
  output logic ext_mode_o              // external clock mode selected
);
  asr_dev_state_type state_reg;
  logic [2:0] cs_sync_reg;
  logic [2:0] sck_sync_reg;
  logic cs_reg;
  logic sck_reg;
  logic cs_next;
  logic sck_next;
  logic cs_fall;
  logic cs_rise;
  logic sck_fall;
  logic sck_rise;
  logic mode_next;
  logic ext_mode_reg;
  logic [12:0] por_cnt_reg;
  logic [7:0] delay_cnt_reg;
  logic [7:0] delay_last;
  logic [5:0] bit_cnt_reg;
  logic [1:0] div_reg;
  logic sck_int_reg;
  logic pullup_reg;
  logic [31:0] shift_reg;
  logic conv_start_reg;

  // Three stages per pin; only the settled level feeds edge logic
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cs_sync_reg <= `ASR_SYNC_RST;
      sck_sync_reg <= `ASR_SYNC_RST;
      cs_reg <= 1'b1;
      sck_reg <= 1'b1;
    end
    else
    begin
      cs_sync_reg <= {cs_sync_reg[1:0], link.cs_n}; // see (RULE23)
      sck_sync_reg <= {sck_sync_reg[1:0], link.sck_line};
      cs_reg <= cs_next;
      sck_reg <= sck_next;
    end
  end

  assign cs_next = asr_settle(cs_reg, cs_sync_reg[1], cs_sync_reg[2]);
  assign sck_next = asr_settle(sck_reg, sck_sync_reg[1], sck_sync_reg[2]);
  assign cs_fall = cs_reg && !cs_next;
  assign cs_rise = !cs_reg && cs_next;
  assign sck_fall = sck_reg && !sck_next;
  assign sck_rise = !sck_reg && sck_next;
  // Low clock at the select fall means the host clocks us
  assign mode_next = cs_fall ? !sck_reg : ext_mode_reg; // see (RULE1)
  assign delay_last = ext_osc_sel_i ? 8'(`ASR_TEST_EXT_CYCLES - 1) : 8'(`ASR_TEST_CYCLES - 1); // see (RULE14)

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      por_cnt_reg <= '0;
    end
    else if (state_reg == ST_POR)
    begin
      por_cnt_reg <= por_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= ST_POR;
      ext_mode_reg <= 1'b0;
      delay_cnt_reg <= '0;
      bit_cnt_reg <= '0;
      div_reg <= '0;
      sck_int_reg <= 1'b1;
      shift_reg <= '0;
      conv_start_reg <= 1'b0;
    end
    else
    begin
      conv_start_reg <= 1'b0;
      ext_mode_reg <= mode_next;
      if (cs_fall)
      begin
        sck_int_reg <= 1'b0; // see (RULE13)
      end
      case (state_reg)
        ST_POR:
        begin
          if (por_cnt_reg == 13'(POR_CYCLES - 1))
          begin
            ext_mode_reg <= !sck_reg; // see (RULE9)
            state_reg <= ST_CONV;
            conv_start_reg <= 1'b1;
          end
        end
        ST_CONV:
        begin
          if (conv_done_i)
          begin
            // Flag bit leads the frame, then the result MSB first
            shift_reg <= {1'b0, conv_data_i}; // see (RULE10) (RULE21)
            if (!mode_next && !cs_reg)
            begin
              state_reg <= ST_TEST;
              delay_cnt_reg <= '0;
              sck_int_reg <= 1'b0;
            end
            else
            begin
              state_reg <= ST_SLEEP; // see (RULE4)
            end
          end
        end
        ST_SLEEP:
        begin
          if (!cs_reg && !mode_next)
          begin
            state_reg <= ST_TEST;
            delay_cnt_reg <= '0;
            sck_int_reg <= 1'b0;
          end
          else if (!cs_reg && mode_next && sck_rise)
          begin
            state_reg <= ST_OUT; // see (RULE5)
            bit_cnt_reg <= 6'h01;
          end
        end
        ST_TEST:
        begin
          if (cs_reg)
          begin
            state_reg <= ST_SLEEP; // see (RULE15)
          end
          else if (delay_cnt_reg == delay_last)
          begin
            state_reg <= ST_OUT; // see (RULE14)
            sck_int_reg <= 1'b1;
            bit_cnt_reg <= 6'h01;
            div_reg <= '0;
          end
          else
          begin
            delay_cnt_reg <= delay_cnt_reg + 1'b1;
          end
        end
        ST_OUT:
        begin
          if (cs_rise)
          begin
            // Abort keeps the clock level; a low clock stays low
            state_reg <= ST_CONV; // see (RULE8) (RULE17) (RULE19)
            conv_start_reg <= 1'b1;
          end
          else if (ext_mode_reg)
          begin
            if (sck_rise)
            begin
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end
            if (sck_fall)
            begin
              if (bit_cnt_reg == 6'(`ASR_FRAME_BITS))
              begin
                state_reg <= ST_CONV; // see (RULE7) (RULE11)
                conv_start_reg <= 1'b1;
              end
              else
              begin
                shift_reg <= {shift_reg[30:0], 1'b0}; // see (RULE6)
              end
            end
          end
          else
          begin
            div_reg <= div_reg + 1'b1;
            if (div_reg == 2'(`ASR_SCK_HALF - 1)) // see (RULE22)
            begin
              div_reg <= '0;
              if (!sck_int_reg)
              begin
                sck_int_reg <= 1'b1;
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
              end
              else if (bit_cnt_reg == 6'(`ASR_FRAME_BITS))
              begin
                state_reg <= ST_CONV; // see (RULE16)
                conv_start_reg <= 1'b1;
              end
              else
              begin
                sck_int_reg <= 1'b0;
                shift_reg <= {shift_reg[30:0], 1'b0}; // see (RULE6)
              end
            end
          end
        end
        default:
        begin
          state_reg <= ST_POR;
        end
      endcase
    end
  end

  // Fall of the pin drops the pull-up; a status pulse restores it
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pullup_reg <= 1'b1;
    end
    else if (state_reg == ST_POR)
    begin
      pullup_reg <= 1'b1; // see (RULE12)
    end
    else if (cs_rise && (state_reg == ST_SLEEP || state_reg == ST_TEST))
    begin
      pullup_reg <= 1'b1; // see (RULE20)
    end
    else if (sck_rise)
    begin
      pullup_reg <= 1'b1; // see (RULE12)
    end
    else if (sck_fall)
    begin
      pullup_reg <= 1'b0; // see (RULE18)
    end
  end

  always_comb
  begin
    case (state_reg)
      ST_OUT: link.dev_sdo = shift_reg[31];
      ST_SLEEP: link.dev_sdo = 1'b0; // see (RULE3)
      ST_TEST: link.dev_sdo = 1'b0;
      default: link.dev_sdo = 1'b1;
    endcase
  end

  assign link.dev_sdo_oe_n = cs_reg || (state_reg == ST_POR); // see (RULE2)
  assign link.dev_sck = sck_int_reg;
  assign link.dev_sck_oe_n = ext_mode_reg || cs_reg || (state_reg == ST_POR); // see (RULE13) (RULE20)
  assign link.dev_sck_pullup = pullup_reg;
  assign conv_start_o = conv_start_reg;
  assign sleep_o = (state_reg == ST_SLEEP);
  assign ext_mode_o = ext_mode_reg;
endmodule

// File: rtl/asr_consts.svh
/*
  Constants of the serial readout link: timing counts, frame size, reset values.
  Assumes a 10 MHz clock on both ends of the link.
*/
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

`define ASR_CLK_PERIOD_NS 100
`define ASR_POR_NS 500000
`define ASR_POR_CYCLES (`ASR_POR_NS / `ASR_CLK_PERIOD_NS)
`define ASR_TEST_NS 23000
`define ASR_TEST_CYCLES ((`ASR_TEST_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_TEST_EXT_X10 36
`define ASR_TEST_EXT_CYCLES ((`ASR_TEST_EXT_X10 + 9) / 10)
`define ASR_SCK_DIV 8
`define ASR_SCK_HALF (`ASR_SCK_DIV / 2)
`define ASR_FRAME_BITS 32
`define ASR_HOST_HALF 8
`define ASR_WORD_W 32
`define ASR_FIFO_DEPTH 16
`define ASR_SYNC_RST 3'h7

`endif

// File: rtl/asr_pkg.sv
/*
  Types and shared helpers of the serial readout link.
  Assumes asr_consts.svh for all numeric values.
*/
package asr_pkg;

  typedef enum logic [4:0] {
    ST_POR   = 5'h01,
    ST_CONV  = 5'h02,
    ST_SLEEP = 5'h04,
    ST_TEST  = 5'h08,
    ST_OUT   = 5'h10
  } asr_dev_state_type;

  typedef enum logic [4:0] {
    H_IDLE   = 5'h01,
    H_PREP   = 5'h02,
    H_SELECT = 5'h04,
    H_CLOCK  = 5'h08,
    H_DONE   = 5'h10
  } asr_host_state_type;

  // Settled level: a change counts once the last two sync stages agree
  function automatic logic asr_settle(input logic prev, input logic s_mid, input logic s_last);
    asr_settle = (s_mid == s_last) ? s_last : prev;
  endfunction

endpackage

// File: rtl/asr_link_if.sv
/*
  Three-wire link between the converter end and the host end.
  Resolves the shared serial clock and data lines from the output enables.
*/
`timescale 1ns/1ps
interface asr_link_if;
  logic cs_n;
  logic host_sck;
  logic host_sck_oe_n;
  logic dev_sck;
  logic dev_sck_oe_n;
  logic dev_sck_pullup;
  logic dev_sdo;
  logic dev_sdo_oe_n;
  logic sck_line;
  logic sdo_line;

  // Undriven clock line follows the weak pull-up, else reads low
  assign sck_line = !dev_sck_oe_n ? dev_sck : (!host_sck_oe_n ? host_sck : dev_sck_pullup);
  assign sdo_line = !dev_sdo_oe_n ? dev_sdo : 1'b1;

  modport dev (input cs_n, input sck_line, output dev_sck, output dev_sck_oe_n,
               output dev_sck_pullup, output dev_sdo, output dev_sdo_oe_n);
  modport host (output cs_n, output host_sck, output host_sck_oe_n, input sck_line, input sdo_line);
endinterface

// File: rtl/asr_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "asr_consts.svh"
module asr_fifo #(
  parameter int unsigned WIDTH = `ASR_WORD_W,
  parameter int unsigned DEPTH = `ASR_FIFO_DEPTH
) (
  input wire logic clk_i,               // clock
  input wire logic sys_rst_i,           // sync reset
  input wire logic [WIDTH-1:0] in_data_i, // write word
  input wire logic in_valid_i,          // write request
  output logic in_ready_o,              // not full
  output logic [WIDTH-1:0] out_data_o,  // head word
  output logic out_valid_o,             // not empty
  input wire logic out_ready_i          // reader takes head
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic push;
  logic pop;

  assign out_valid_o = (wr_ptr_reg != rd_ptr_reg);
  assign in_ready_o = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

// File: rtl/asr_host.sv
/*
  Host end of the three-wire readout link: selects, tests status, clocks or
  follows 32 bits, and queues each frame in a 16-word FIFO.
  Assumes the converter end on the same 10 MHz clock domain rules.
*/
`timescale 1ns/1ps
`include "asr_consts.svh"
module asr_host
  import asr_pkg::*;
(
  input wire logic clk_i,           // clock
  input wire logic sys_rst_i,       // sync reset, active high
  asr_link_if.host link,            // three-wire link
  input wire logic start_i,         // request one frame
  input wire logic ext_mode_i,      // host drives the serial clock
  output logic [31:0] word_o,       // frame: flag bit then result
  output logic word_valid_o,        // word available
  input wire logic word_ready_i,    // user takes word
  output logic busy_o               // frame in progress
);
  asr_host_state_type state_reg;
  logic [2:0] sck_sync_reg;
  logic [2:0] sdo_sync_reg;
  logic sck_reg;
  logic sdo_reg;
  logic sck_next;
  logic sdo_next;
  logic sck_rise;
  logic mode_reg;
  logic cs_n_reg;
  logic sck_out_reg;
  logic [3:0] half_reg;
  logic [5:0] bit_reg;
  logic [31:0] rx_reg;
  logic push;
  logic fifo_ready;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sck_sync_reg <= `ASR_SYNC_RST;
      sdo_sync_reg <= `ASR_SYNC_RST;
      sck_reg <= 1'b1;
      sdo_reg <= 1'b1;
    end
    else
    begin
      sck_sync_reg <= {sck_sync_reg[1:0], link.sck_line};
      sdo_sync_reg <= {sdo_sync_reg[1:0], link.sdo_line};
      sck_reg <= sck_next;
      sdo_reg <= sdo_next;
    end
  end

  assign sck_next = asr_settle(sck_reg, sck_sync_reg[1], sck_sync_reg[2]);
  // Round trip through both syncs is a full half period; the registered copy lags
  assign sdo_next = asr_settle(sdo_reg, sdo_sync_reg[1], sdo_sync_reg[2]);
  assign sck_rise = !sck_reg && sck_next;
  // One push per frame, on the first done cycle
  assign push = (state_reg == H_DONE) && (half_reg == 4'h0);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= H_IDLE;
      mode_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      sck_out_reg <= 1'b0;
      half_reg <= '0;
      bit_reg <= '0;
      rx_reg <= '0;
    end
    else
    begin
      case (state_reg)
        H_IDLE:
        begin
          // No frame starts without room to store it
          if (start_i && fifo_ready)
          begin
            mode_reg <= ext_mode_i;
            sck_out_reg <= 1'b0;
            half_reg <= '0;
            state_reg <= H_PREP;
          end
        end
        H_PREP:
        begin
          // Clock level must settle at the far end before select falls
          half_reg <= half_reg + 1'b1;
          if (half_reg == 4'(`ASR_HOST_HALF - 1))
          begin
            cs_n_reg <= 1'b0;
            half_reg <= '0;
            bit_reg <= '0;
            state_reg <= H_SELECT;
          end
        end
        H_SELECT:
        begin
          half_reg <= half_reg + 1'b1;
          if (half_reg == 4'(`ASR_HOST_HALF - 1) && !sdo_reg)
          begin
            half_reg <= '0;
            state_reg <= H_CLOCK;
          end
          else if (half_reg == 4'(`ASR_HOST_HALF - 1))
          begin
            half_reg <= half_reg;
          end
        end
        H_CLOCK:
        begin
          if (mode_reg)
          begin
            half_reg <= half_reg + 1'b1;
            if (half_reg == 4'(`ASR_HOST_HALF - 1))
            begin
              half_reg <= '0;
              sck_out_reg <= !sck_out_reg;
              if (!sck_out_reg)
              begin
                rx_reg <= {rx_reg[30:0], sdo_next}; // see (RULE6)
                bit_reg <= bit_reg + 1'b1;
              end
              else if (bit_reg == 6'(`ASR_FRAME_BITS))
              begin
                state_reg <= H_DONE;
              end
            end
          end
          else if (sck_rise)
          begin
            rx_reg <= {rx_reg[30:0], sdo_reg};
            bit_reg <= bit_reg + 1'b1;
            if (bit_reg == 6'(`ASR_FRAME_BITS - 1))
            begin
              state_reg <= H_DONE;
            end
          end
        end
        H_DONE:
        begin
          // Far end must see deselect before the next frame may drive the clock
          half_reg <= half_reg + 1'b1;
          if (!mode_reg)
          begin
            cs_n_reg <= 1'b1;
            if (half_reg == 4'(`ASR_HOST_HALF - 1))
            begin
              half_reg <= '0;
              state_reg <= H_IDLE;
            end
          end
          else if (half_reg == 4'(`ASR_HOST_HALF - 1))
          begin
            // Last fall held long enough to be counted
            cs_n_reg <= 1'b1; // see (RULE7) (RULE11)
          end
          else if (half_reg == 4'(`ASR_HOST_HALF + `ASR_HOST_HALF / 2 - 1))
          begin
            // Line back high first, else the released pin floats low
            sck_out_reg <= 1'b1; // see (RULE18) (RULE19)
          end
          else if (half_reg == 4'(2 * `ASR_HOST_HALF - 1))
          begin
            state_reg <= H_IDLE;
          end
        end
        default:
        begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  asr_fifo #(
    .WIDTH(`ASR_WORD_W),
    .DEPTH(`ASR_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(rx_reg),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .out_data_o(word_o),
    .out_valid_o(word_valid_o),
    .out_ready_i(word_ready_i)
  );

  assign link.cs_n = cs_n_reg;
  assign link.host_sck = sck_out_reg;
  // Internal mode leaves the clock to the converter and its pull-up
  assign link.host_sck_oe_n = !mode_reg || (state_reg == H_IDLE);
  assign busy_o = (state_reg != H_IDLE);
endmodule

// File: verification/asr_link_assertions.sv
/*
  Link checker: timing relations on the three-wire link between the two ends.
  Takes the link signals as plain inputs; the bench instantiates it beside the link.
*/
`timescale 1ns/1ps
module asr_link_assertions (
  input wire logic clk_i,          // clock
  input wire logic sys_rst_i,      // sync reset
  input wire logic cs_n,           // select, low active
  input wire logic host_sck_oe_n,  // host drives clock when low
  input wire logic dev_sck,        // device clock value
  input wire logic dev_sck_oe_n,   // device drives clock when low
  input wire logic dev_sck_pullup, // weak pull-up enable
  input wire logic dev_sdo_oe_n,   // device drives data when low
  input wire logic sck_line,       // resolved clock
  input wire logic sdo_line        // resolved data
);
  logic sck_prev_reg;
  logic [5:0] rise_cnt_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  always_ff @(posedge clk_i)
  begin
    sck_prev_reg <= dev_sck;
  end

  // Device-made clock rises within one selection
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || cs_n)
      rise_cnt_reg <= 6'h00;
    else if (!dev_sck_oe_n && dev_sck && !sck_prev_reg)
      rise_cnt_reg <= rise_cnt_reg + 6'h01;
  end

  sequence int_rise_s;
    !dev_sck_oe_n && $rose(dev_sck);
  endsequence

  sequence high_phase_s;
    int_rise_s ##4 !dev_sck;
  endsequence

  sdo_hiz_a: assert property (cs_n [*5] |-> dev_sdo_oe_n)
    else $error("data out driven while deselected");
  sdo_flag_a: assert property (!cs_n [*5] |-> !dev_sdo_oe_n)
    else $error("data out not driven while selected");
  no_fight_a: assert property (!host_sck_oe_n |-> dev_sck_oe_n)
    else $error("both ends drive the clock");
  pullup_sel_a: assert property ($fell(cs_n) && host_sck_oe_n |-> dev_sck_pullup)
    else $error("pull-up off at select fall");
  pullup_off_a: assert property (!sck_line [*6] |-> !dev_sck_pullup)
    else $error("pull-up on while clock low");
  int_low_a: assert property ($fell(cs_n) && sck_line |-> ##[1:8] (!dev_sck_oe_n && !dev_sck))
    else $error("clock not driven low after select");
  sck_high_a: assert property (int_rise_s |-> dev_sck [*4])
    else $error("clock high phase too short");
  sck_half_a: assert property (high_phase_s |-> !dev_sck [*4] ##1 dev_sck)
    else $error("clock low phase wrong");
  rise_max_a: assert property (rise_cnt_reg <= 6'h20)
    else $error("more than 32 clock rises");
  hold_high_a: assert property (rise_cnt_reg == 6'h20 && !cs_n |-> dev_sck && !dev_sck_oe_n)
    else $error("clock not held high after frame");
  sdo_end_a: assert property ($rose(rise_cnt_reg == 6'h20) |-> ##[0:4] sdo_line)
    else $error("data out not high after frame");
endmodule

// File: verification/adc_serial_readout_interface_tb.sv
/*
  Bench: host end and converter end over one link, plus a second converter
  end driven pin by pin for aborts and status tests. Assumes POR of 20 cycles.
*/
`timescale 1ns/1ps
module adc_serial_readout_interface_tb;
  localparam int LIMIT = 40000;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic start_i = 1'b0;
  logic ext_mode_i = 1'b0;
  logic word_ready_i = 1'b0;
  logic [31:0] word_o;
  logic word_valid_o;
  logic busy_o;
  logic osc[2] = '{1'b0, 1'b0};
  logic c_done[2] = '{1'b0, 1'b0};
  logic pd[2] = '{1'b0, 1'b0};
  logic c_start[2];
  logic sleep[2];
  logic emode[2];
  logic [30:0] c_data[2] = '{31'h0, 31'h0};
  logic [31:0] rng = 32'h0001595b;
  logic [31:0] r;
  logic [30:0] exp_q[$];
  int cd[2] = '{0, 0};
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;

  asr_link_if la();
  asr_link_if lb();
  asr_dev #(.POR_CYCLES(20)) i_asr_dev (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(la.dev),
    .ext_osc_sel_i(osc[0]), .conv_done_i(c_done[0]), .conv_data_i(c_data[0]),
    .conv_start_o(c_start[0]), .sleep_o(sleep[0]), .ext_mode_o(emode[0]));
  asr_dev #(.POR_CYCLES(20)) i_asr_dev_b (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(lb.dev),
    .ext_osc_sel_i(osc[1]), .conv_done_i(c_done[1]), .conv_data_i(c_data[1]),
    .conv_start_o(c_start[1]), .sleep_o(sleep[1]), .ext_mode_o(emode[1]));
  asr_host i_asr_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(la.host), .start_i(start_i),
    .ext_mode_i(ext_mode_i), .word_o(word_o), .word_valid_o(word_valid_o),
    .word_ready_i(word_ready_i), .busy_o(busy_o));
  asr_link_assertions i_asr_link_assertions (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n(la.cs_n),
    .host_sck_oe_n(la.host_sck_oe_n), .dev_sck(la.dev_sck), .dev_sck_oe_n(la.dev_sck_oe_n),
    .dev_sck_pullup(la.dev_sck_pullup), .dev_sdo_oe_n(la.dev_sdo_oe_n), .sck_line(la.sck_line),
    .sdo_line(la.sdo_line));

  initial
  begin
    lb.cs_n = 1'b1;
    lb.host_sck = 1'b0;
    lb.host_sck_oe_n = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Frame on the wire: flag bit low, then the result
  function automatic logic [31:0] frame_word(input logic [30:0] d);
    return {1'b0, d};
  endfunction

  function automatic logic sg(input int w);
    case (w)
      0: return busy_o;
      1: return sleep[1];
      2: return c_start[1];
      default: return lb.sck_line;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wt(input int w, input logic v, input int lim);
    int t;
    t = 0;
    do
    begin
      @(negedge clk_i);
      t++;
    end
    while (sg(w) !== v && t < lim);
    chk("wait", 32'(v), 32'(sg(w)));
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic frame(input logic [31:0] v);
    @(posedge clk_i);
    ext_mode_i <= v[0];
    osc[0] <= v[1];
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    wt(0, 1'b1, 20);
    wt(0, 1'b0, 4000);
    chk("mode", 32'(v[0]), 32'(emode[0]));
  endtask

  // Core stand-ins: done 5 to 44 cycles after each start
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    for (int k = 0; k < 2; k++)
    begin
      c_done[k] <= 1'b0;
      if (c_start[k] === 1'b1)
        cd[k] <= 5 + int'(rnd() % 40);
      else if (cd[k] > 0)
        cd[k] <= cd[k] - 1;
      if (cd[k] == 1)
      begin
        r = rnd();
        c_done[k] <= 1'b1;
        c_data[k] <= r[30:0];
        if (k == 0)
          exp_q.push_back(r[30:0]);
      end
    end
    if (cyc == LIMIT)
    begin
      mismatches++;
      summarize();
    end
  end

  always @(negedge clk_i)
  begin
    if (word_valid_o === 1'b1 && word_ready_i === 1'b1)
      chk("word", frame_word(exp_q.pop_front()), word_o);
    for (int k = 0; k < 2; k++)
      if (pd[k] === 1'b1 && (k == 0 ? la.cs_n : lb.cs_n) === 1'b1)
        chk("sleep", 32'h1, 32'(sleep[k]));
    pd <= c_done;
  end

  initial
  begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (60) @(negedge clk_i);
    chk("por_mode", 32'h0, 32'(emode[0]));
    chk("por_mode_b", 32'h1, 32'(emode[1]));
    @(posedge clk_i);
    word_ready_i <= 1'b1;
    for (int i = 0; i < 4; i++)
      frame(32'(i));
    repeat (6) frame(rnd());
    // Reader stalls: 16 frames fill the queue, one more is refused
    @(posedge clk_i);
    word_ready_i <= 1'b0;
    repeat (16) frame(rnd());
    @(posedge clk_i);
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    repeat (40) @(negedge clk_i);
    chk("refused", 32'h0, 32'(busy_o));
    @(posedge clk_i);
    word_ready_i <= 1'b1;
    repeat (40) @(negedge clk_i);
    chk("drained", 32'h0, 32'(word_valid_o));
    frame(rnd());
    // Second end, external clock: three bits, then abort
    wt(1, 1'b1, 100);
    @(posedge clk_i);
    lb.cs_n <= 1'b0;
    repeat (8) @(negedge clk_i);
    chk("flag", 32'h0, 32'(lb.sdo_line));
    for (int i = 0; i < 6; i++)
    begin
      repeat (8) @(posedge clk_i);
      lb.host_sck <= ~lb.host_sck;
    end
    repeat (8) @(posedge clk_i);
    lb.cs_n <= 1'b1;
    wt(2, 1'b1, 20);
    repeat (6) @(negedge clk_i);
    chk("hiz", 32'h1, 32'(lb.dev_sdo_oe_n));
    // Hand the clock line back high, then a short status pulse
    @(posedge clk_i);
    lb.host_sck <= 1'b1;
    repeat (10) @(posedge clk_i);
    lb.host_sck_oe_n <= 1'b1;
    wt(1, 1'b1, 100);
    chk("pullup", 32'h1, 32'(lb.sck_line));
    @(posedge clk_i);
    lb.cs_n <= 1'b0;
    repeat (60) @(negedge clk_i);
    chk("sck_low", 32'h0, 32'(lb.sck_line));
    chk("flag_int", 32'h0, 32'(lb.sdo_line));
    chk("int_mode", 32'h0, 32'(emode[1]));
    @(posedge clk_i);
    lb.cs_n <= 1'b1;
    repeat (30) @(negedge clk_i);
    chk("asleep", 32'h1, 32'(sleep[1]));
    chk("pullup_back", 32'h1, 32'(lb.sck_line));
    // Internal clock with short status delay, abort after two rises
    @(posedge clk_i);
    osc[1] <= 1'b1;
    lb.cs_n <= 1'b0;
    wt(3, 1'b0, 20);
    wt(3, 1'b1, 60);
    repeat (10) @(posedge clk_i);
    lb.cs_n <= 1'b1;
    wt(2, 1'b1, 20);
    summarize();
  end
endmodule
